// >>> inc/rx_align_defs.svh
// Purpose: named offsets, field positions, counts and codes of the
//          receive serial port frame aligner
// Assumes: included by the package only
// Notes:   definitions only
`ifndef RX_ALIGN_DEFS_SVH
`define RX_ALIGN_DEFS_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define RA_CTRL_ADDR       32'h0000_0000
`define RA_STATUS_ADDR     32'h0000_0004
`define RA_DATA_ADDR       32'h0000_0008

// ----------------------------------------------------------------
// register fields
// ----------------------------------------------------------------
`define RA_CTRL_W          6
`define RA_CTRL_RESET      6'h00
`define RA_STAT_ALIGN_BIT  0
`define RA_STAT_SEEN_BIT   1
`define RA_STAT_POS_LSB    16
`define RA_DATA_BYTE_LSB   0

// ----------------------------------------------------------------
// axi4-lite responses
// ----------------------------------------------------------------
`define RA_RESP_OKAY       2'h0
`define RA_RESP_SLVERR     2'h2

// ----------------------------------------------------------------
// frame position: last count of each line mode, early presets
// ----------------------------------------------------------------
`define RA_POS_W           10
`define RA_LAST_T1         10'h0C0
`define RA_LAST_E1         10'h0FF
`define RA_LAST_4M         10'h1FF
`define RA_LAST_8M         10'h3FF
`define RA_POS_FIRST       10'h000
`define RA_POS_SECOND      10'h001
`define RA_BYTE_LAST_BIT   3'h7
`define RA_BYTE_FIRST_BIT  3'h0

// ----------------------------------------------------------------
// line clock rates the edge finder has to resolve
// ----------------------------------------------------------------
`define RA_ACLK_MHZ        250
`define RA_FAST_LINE_MHZ   52
`define RA_SLOW_LINE_MHZ   10

`endif

// >>> inc/rx_align_pkg.sv
// Purpose: types of the receive serial port frame aligner
// Assumes: rx_align_defs.svh gives widths
// Notes:   no imports are used anywhere; refer as rx_align_pkg::name
`include "rx_align_defs.svh"

package rx_align_pkg;

  // ----------------------------------------------------------------
  // modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LM_T1 = 2'b00,
    LM_E1 = 2'b01,
    LM_4M = 2'b10,
    LM_8M = 2'b11
  } line_mode_e;

  typedef enum logic [1:0] {
    EARLY_0    = 2'b00,
    EARLY_HALF = 2'b01,
    EARLY_1    = 2'b10,
    EARLY_2    = 2'b11
  } early_e;

  // ----------------------------------------------------------------
  // control register layout, msb first: [5:4] [3:2] [1] [0]
  // ----------------------------------------------------------------
  typedef struct packed {
    line_mode_e line_mode;
    early_e     early;
    logic       sync_inv;
    logic       clk_inv;
  } ctrl_s;

  // ----------------------------------------------------------------
  // aligned receive stream towards the consumer
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                    bit_data;
    logic                    bit_valid;
    logic                    frame_start;
    logic [7:0]              byte_data;
    logic                    byte_valid;
    logic [`RA_POS_W-1:0]    pos;
  } rx_stream_s;

  // ----------------------------------------------------------------
  // state of the pin synchroniser and edge finder
  // ----------------------------------------------------------------
  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } edge_s;

  // ----------------------------------------------------------------
  // whole state of the aligner
  // ----------------------------------------------------------------
  typedef struct packed {
    ctrl_s                ctrl;
    logic                 aligned;
    logic                 sync_seen;
    logic                 pend;
    logic [`RA_POS_W-1:0] pend_val;
    logic [7:0]           shreg;
    rx_stream_s           stream;
    logic                 awready;
    logic                 wready;
    logic                 aw_got;
    logic                 w_got;
    logic [31:0]          awaddr;
    logic [31:0]          wdata;
    logic [3:0]           wstrb;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 arready;
    logic                 rvalid;
    logic [31:0]          rdata;
    logic [1:0]           rresp;
  } state_s;

endpackage

// >>> src/rx_edge_sync.sv
// Purpose: two-flop synchroniser for one pin with edge finder
// Assumes: pin is asynchronous to aclk
// Notes:   the first flop feeds only the second
`timescale 1ns/1ps

module rx_edge_sync (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  rx_align_pkg::edge_s s_ff;
  rx_align_pkg::edge_s nxt_s;

  // shift the pin through the chain
  always_comb begin
    nxt_s      = s_ff;
    nxt_s.meta = pin;
    nxt_s.sync = s_ff.meta;
    nxt_s.last = s_ff.sync;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // edges seen between second and third flop
  assign level = s_ff.sync;
  assign rise  = s_ff.sync & ~s_ff.last;
  assign fall  = ~s_ff.sync & s_ff.last;

endmodule

// >>> src/rx_align_top.sv
// Purpose: receive serial port front end: samples line data, takes the
//          frame sync and keeps byte and frame position
// Assumes: line clock, data and sync are asynchronous pins, oversampled
//          by aclk at 250 MHz; registers over AXI4-Lite
// Notes:   every output is a flop of the state struct
//
// Register access over AXI4-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ps

module rx_align_top (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               rx_line_clock,
  input  wire logic               rx_data,
  input  wire logic               rx_frame_sync,
  input  wire logic [31:0]        s_axi_awaddr,
  input  wire logic [2:0]         s_axi_awprot,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [31:0]        s_axi_araddr,
  input  wire logic [2:0]         s_axi_arprot,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  output rx_align_pkg::rx_stream_s rx_stream,
  output logic                    rx_aligned
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // last frame position of a line mode
  function automatic logic [`RA_POS_W-1:0] frame_last(input rx_align_pkg::line_mode_e m);
    case (m)
      rx_align_pkg::LM_T1: frame_last = `RA_LAST_T1;
      rx_align_pkg::LM_E1: frame_last = `RA_LAST_E1;
      rx_align_pkg::LM_4M: frame_last = `RA_LAST_4M;
      default:             frame_last = `RA_LAST_8M;
    endcase
  endfunction

  // position the next data edge takes after an early sync
  function automatic logic [`RA_POS_W-1:0] early_preset(input rx_align_pkg::ctrl_s c);
    case (c.early)
      rx_align_pkg::EARLY_0: early_preset = `RA_POS_SECOND;
      rx_align_pkg::EARLY_1: early_preset = `RA_POS_FIRST;
      rx_align_pkg::EARLY_2: early_preset = frame_last(c.line_mode);
      default:               early_preset = `RA_POS_FIRST;
    endcase
  endfunction

  // last bit of a byte; t1 frames lead with one framing bit
  function automatic logic byte_end(input logic [`RA_POS_W-1:0] p,
                                    input rx_align_pkg::line_mode_e m);
    if (m == rx_align_pkg::LM_T1) begin
      byte_end = (p[2:0] == `RA_BYTE_FIRST_BIT) && (p != `RA_POS_FIRST);
    end else begin
      byte_end = (p[2:0] == `RA_BYTE_LAST_BIT);
    end
  endfunction

  // register index of an address: 0 ctrl, 1 status, 2 data, 3 none
  function automatic logic [1:0] reg_sel(input logic [31:0] a);
    case ({a[31:2], 2'h0})
      `RA_CTRL_ADDR:   reg_sel = 2'h0;
      `RA_STATUS_ADDR: reg_sel = 2'h1;
      `RA_DATA_ADDR:   reg_sel = 2'h2;
      default:         reg_sel = 2'h3;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic clk_rise;
  logic clk_fall;
  logic data_lvl;
  logic sync_lvl;

  rx_edge_sync u_clk_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (rx_line_clock),
    .level   (),
    .rise    (clk_rise),
    .fall    (clk_fall)
  );

  rx_edge_sync u_data_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (rx_data),
    .level   (data_lvl),
    .rise    (),
    .fall    ()
  );

  rx_edge_sync u_fsync_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (rx_frame_sync),
    .level   (sync_lvl),
    .rise    (),
    .fall    ()
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  rx_align_pkg::state_s s_ff;
  rx_align_pkg::state_s nxt_s;

  logic                 data_edge;
  logic                 sync_edge;
  logic                 sync_hit;
  logic                 half;
  logic [`RA_POS_W-1:0] nxt_pos;
  logic [31:0]          rd_val;

  // next state: bus slave first, then link, so hardware sets win
  always_comb begin
    nxt_s = s_ff;
    nxt_s.stream.bit_valid   = 1'b0;
    nxt_s.stream.frame_start = 1'b0;
    nxt_s.stream.byte_valid  = 1'b0;
    nxt_pos = s_ff.stream.pos;
    rd_val  = '0;

    // write channel: address and data taken in either order
    if (s_ff.bvalid && s_axi_bready) begin
      nxt_s.bvalid = 1'b0;
    end
    if (s_axi_awvalid && s_ff.awready) begin
      nxt_s.aw_got = 1'b1;
      nxt_s.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_ff.wready) begin
      nxt_s.w_got = 1'b1;
      nxt_s.wdata = s_axi_wdata;
      nxt_s.wstrb = s_axi_wstrb;
    end
    if (nxt_s.aw_got && nxt_s.w_got) begin
      nxt_s.aw_got = 1'b0;
      nxt_s.w_got  = 1'b0;
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp  = `RA_RESP_OKAY;
      case (reg_sel(nxt_s.awaddr))
        2'h0: begin
          if (nxt_s.wstrb[0]) begin
            nxt_s.ctrl    = rx_align_pkg::ctrl_s'(nxt_s.wdata[`RA_CTRL_W-1:0]);
            nxt_s.aligned = 1'b0;  // new mode needs a fresh sync
            nxt_s.pend    = 1'b0;
          end
        end
        2'h1: begin
          if (nxt_s.wstrb[0] && nxt_s.wdata[`RA_STAT_SEEN_BIT]) begin
            nxt_s.sync_seen = 1'b0;  // write one to clear
          end
        end
        2'h2: begin
          nxt_s.bresp = `RA_RESP_OKAY;  // read only, write ignored
        end
        default: begin
          nxt_s.bresp = `RA_RESP_SLVERR;
        end
      endcase
    end
    nxt_s.awready = !nxt_s.aw_got && !nxt_s.bvalid;
    nxt_s.wready  = !nxt_s.w_got && !nxt_s.bvalid;

    // read channel
    if (s_ff.rvalid && s_axi_rready) begin
      nxt_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_ff.arready) begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rresp  = `RA_RESP_OKAY;
      case (reg_sel(s_axi_araddr))
        2'h0: begin
          rd_val[`RA_CTRL_W-1:0] = s_ff.ctrl;
        end
        2'h1: begin
          rd_val[`RA_STAT_ALIGN_BIT] = s_ff.aligned;
          rd_val[`RA_STAT_SEEN_BIT]  = s_ff.sync_seen;
          rd_val[`RA_STAT_POS_LSB +: `RA_POS_W] = s_ff.stream.pos;
        end
        2'h2: begin
          rd_val[`RA_DATA_BYTE_LSB +: 8] = s_ff.stream.byte_data;
        end
        default: begin
          nxt_s.rresp = `RA_RESP_SLVERR;
        end
      endcase
      nxt_s.rdata = rd_val;
    end
    nxt_s.arready = !nxt_s.rvalid;

    data_edge = s_ff.ctrl.clk_inv ? clk_fall : clk_rise;
    half      = (s_ff.ctrl.early == rx_align_pkg::EARLY_HALF);
    // sync on opposite edge unless half early
    sync_edge = half ? data_edge : (s_ff.ctrl.clk_inv ? clk_rise : clk_fall);
    // one sampled active level marks the frame
    // a sync held inactive never realigns
    sync_hit  = sync_edge && (sync_lvl ^ s_ff.ctrl.sync_inv);

    // early sync arms a preset for next data edge
    if (sync_hit && !half) begin
      nxt_s.pend     = 1'b1;
      nxt_s.pend_val = early_preset(s_ff.ctrl);
    end
    if (sync_hit) begin
      nxt_s.aligned   = 1'b1;
      nxt_s.sync_seen = 1'b1;
    end

    if (data_edge) begin
      // half early sync lands on this very bit
      if (half && sync_hit) begin
        nxt_pos = `RA_POS_FIRST;
      end else if (s_ff.pend) begin
        nxt_pos    = s_ff.pend_val;
        nxt_s.pend = 1'b0;
      end else if (s_ff.stream.pos >= frame_last(s_ff.ctrl.line_mode)) begin
        nxt_pos = `RA_POS_FIRST;
      end else begin
        nxt_pos = s_ff.stream.pos + `RA_POS_SECOND;
      end
      nxt_s.stream.pos         = nxt_pos;
      nxt_s.stream.bit_data    = data_lvl;
      nxt_s.stream.bit_valid   = 1'b1;
      nxt_s.stream.frame_start = (nxt_pos == `RA_POS_FIRST);
      nxt_s.shreg              = {s_ff.shreg[6:0], data_lvl};
      // first bit of a byte ends up as the msb
      if (byte_end(nxt_pos, s_ff.ctrl.line_mode)) begin
        nxt_s.stream.byte_data  = {s_ff.shreg[6:0], data_lvl};
        nxt_s.stream.byte_valid = 1'b1;
      end
    end
  end

  // register the whole state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_ff      <= '0;
      s_ff.ctrl <= rx_align_pkg::ctrl_s'(`RA_CTRL_RESET);
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from state flops
  // ----------------------------------------------------------------
  assign s_axi_awready = s_ff.awready;
  assign s_axi_wready  = s_ff.wready;
  assign s_axi_bvalid  = s_ff.bvalid;
  assign s_axi_bresp   = s_ff.bresp;
  assign s_axi_arready = s_ff.arready;
  assign s_axi_rvalid  = s_ff.rvalid;
  assign s_axi_rdata   = s_ff.rdata;
  assign s_axi_rresp   = s_ff.rresp;
  assign rx_stream     = s_ff.stream;
  assign rx_aligned    = s_ff.aligned;

endmodule

// >>> testbench/rx_align_checker.sv
// Purpose: port-level checks of the receive frame aligner
// Assumes: one aclk domain, reset disables every check
// Notes:   age_ff gates checks until alignment has settled
`timescale 1ns/1ps

module rx_align_checker (
  input wire logic                     aclk,
  input wire logic                     aresetn,
  input wire logic                     s_axi_wvalid,
  input wire logic                     s_axi_arvalid,
  input wire logic                     s_axi_arready,
  input wire logic                     s_axi_rvalid,
  input wire rx_align_pkg::rx_stream_s rx_stream,
  input wire logic                     rx_aligned
);
  logic [6:0] age_ff;
  logic [9:0] prev_pos_ff;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // cycles since alignment, position of the previous bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      age_ff      <= 7'h00;
      prev_pos_ff <= 10'h000;
    end else begin
      age_ff <= !rx_aligned ? 7'h00 : ((age_ff == 7'h7F) ? age_ff : age_ff + 7'h01);
      if (rx_stream.bit_valid)
        prev_pos_ff <= rx_stream.pos;
    end
  end

  sequence s_bit; rx_stream.bit_valid; endsequence
  sequence s_settled; rx_aligned && age_ff == 7'h7F; endsequence

  property p_fs_zero; rx_stream.frame_start |-> s_bit ##0 rx_stream.pos == 10'h000; endproperty
  a_fs_zero: assert property (p_fs_zero) else $error("frame start off zero");
  property p_pos_step; s_settled ##0 s_bit ##0 rx_stream.pos != 10'h000
    |-> rx_stream.pos == prev_pos_ff + 10'h001; endproperty
  a_pos_step: assert property (p_pos_step) else $error("position skipped");
  property p_wrap; s_settled ##0 s_bit ##0 rx_stream.pos == 10'h000
    |-> prev_pos_ff inside {10'h0C0, 10'h0FF, 10'h1FF, 10'h3FF}; endproperty
  a_wrap: assert property (p_wrap) else $error("wrap from wrong position");
  property p_bit_gap; s_bit |=> !rx_stream.bit_valid [*3]; endproperty
  a_bit_gap: assert property (p_bit_gap) else $error("bits too close");
  property p_byte_end; rx_stream.byte_valid
    |-> rx_stream.bit_valid && rx_stream.pos[2:0] inside {3'h7, 3'h0}; endproperty
  a_byte_end: assert property (p_byte_end) else $error("byte off boundary");
  property p_held; !rx_stream.bit_valid |-> $stable(rx_stream.pos)
    && $stable(rx_stream.bit_data) && $stable(rx_stream.byte_data); endproperty
  a_held: assert property (p_held) else $error("stream changed without a bit");
  property p_keep; rx_aligned && !s_axi_wvalid && !$past(s_axi_wvalid) |=> rx_aligned;
  endproperty
  a_keep: assert property (p_keep) else $error("alignment lost without a write");
  property p_rd_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered in one cycle");
endmodule

bind rx_align_top rx_align_checker u_chk (.aclk, .aresetn, .s_axi_wvalid, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .rx_stream, .rx_aligned);

// >>> testbench/rx_line_model.sv
// Purpose: line interface partner: line clock, data and sync pulse
// Assumes: line clock period 125 ns while run is high
// Notes:   data and sync move on the edge the aligner does not sample
`timescale 1ns/1ps

module rx_line_model (
  input  wire logic       run,
  input  wire logic       clk_inv,
  input  wire logic       sync_inv,
  input  wire logic       half,
  input  wire logic       sync_req,
  input  wire logic [7:0] pat,
  output logic            rx_line_clock,
  output logic            rx_data,
  output logic            rx_frame_sync
);
  logic lvl, req_seen, first;
  int   idx;

  // line clock stands low until run; pattern sent msb first
  initial begin
    rx_line_clock = 1'b0;
    rx_data = 1'b0;
    rx_frame_sync = 1'b0;
    lvl = 1'b0;
    req_seen = 1'b0;
    first = 1'b0;
    idx = 0;
    forever begin
      #62.5;
      if (run === 1'b1) begin
        lvl = ~lvl;
        rx_line_clock = lvl;
        if (lvl == (half ? clk_inv : ~clk_inv)) begin
          rx_frame_sync = (sync_req && !req_seen) ? ~sync_inv : sync_inv;
          first = first | (sync_req && !req_seen);
          req_seen = sync_req;
        end
        if (lvl == clk_inv) begin
          idx = first ? 0 : (idx + 1) % 8;
          first = 1'b0;
          rx_data = pat[3'(7 - idx)];
        end
      end
    end
  end
endmodule

// >>> testbench/test_rx_align_top.sv
// Purpose: self-checking bench of the receive frame aligner
// Assumes: partner model drives the line pins, bench is bus master
// Notes:   after the blocking setup at time 0, all bench drives land by nba after a rising edge
`timescale 1ns/1ps

module test_rx_align_top;
  logic aclk, aresetn, run, clk_inv, sync_inv, half, sync_req;
  logic rx_line_clock, rx_data, rx_frame_sync, rx_aligned;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [7:0]  pat;
  rx_align_pkg::rx_stream_s rx_stream, st;
  int n_mismatch, checks;

  rx_align_top u_dut (.aclk, .aresetn, .rx_line_clock, .rx_data, .rx_frame_sync,
    .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_stream, .rx_aligned);
  rx_line_model u_line (.run, .clk_inv, .sync_inv, .half, .sync_req, .pat,
    .rx_line_clock, .rx_data, .rx_frame_sync);

  // 250 mhz system clock
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic summarize;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic tmo;
    n_mismatch++;
    $display("[FAIL] %0t wait ran out", $time);
    summarize();
  endtask

  // ----------------------------------------------------------------
  // bus cycles and line waits
  // ----------------------------------------------------------------
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] exp);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, exp}, "write response");
        break;
      end
    end
    if (n == 50) tmo();
  endtask

  task automatic rdr(input logic [31:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        s_axi_rready <= 1'b0;
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        break;
      end
    end
    if (n == 50) tmo();
  endtask

  // next sampled line bit lands in st
  task automatic wbit;
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (rx_stream.bit_valid !== 1'b1 && n < 200);
    if (n == 200) tmo();
    st = rx_stream;
  endtask

  // set modes on both sides at once, let a stale sync level pass, write again
  // to drop any alignment it caused, then ask the partner for one sync pulse
  task automatic cfg(input logic [1:0] mode, input logic [1:0] early, input logic si,
                     input logic ci);
    rx_align_pkg::ctrl_s c;
    c = '{rx_align_pkg::line_mode_e'(mode), rx_align_pkg::early_e'(early), si, ci};
    clk_inv <= ci;
    sync_inv <= si;
    half <= (early == 2'b01);
    sync_req <= 1'b0;
    wr(32'h0, {26'h0, c}, 2'h0);
    repeat (80) @(posedge aclk);
    wr(32'h0, {26'h0, c}, 2'h0);
    repeat (80) @(posedge aclk);
    rdr(32'h4);
    chk({31'h0, rd[0]}, 32'h0, "inactive sync taken");
    sync_req <= 1'b1;
  endtask

  task automatic s_regs;
    rdr(32'h0);
    chk(rd, 32'h0, "ctrl reset value");
    rdr(32'h10);
    chk({30'h0, resp}, 32'h2, "unmapped read response");
    chk(rd, 32'h0, "unmapped read data");
    wr(32'h10, 32'hFFFF_FFFF, 2'h2);
    wr(32'h8, 32'h0000_00FF, 2'h0);
    rdr(32'h0);
    chk(rd, 32'h0, "ctrl changed by stray write");
  endtask

  // every early offset, both clock and sync polarities, e1 bytes
  task automatic s_sync;
    logic [3:0]  tbl [4] = '{4'b0000, 4'b0111, 4'b1001, 4'b1110};
    int          off [4] = '{1, 0, 0, 255};
    logic [15:0] w;
    int          n;
    for (int i = 0; i < 4; i++) begin
      cfg(2'b01, tbl[i][3:2], tbl[i][1], tbl[i][0]);
      repeat (24) wbit();
      rdr(32'h4);
      chk({30'h0, rd[1:0]}, 32'h3, "aligned and seen");
      chk({31'h0, rx_aligned}, 32'h1, "aligned pin");
      n = 0;
      do begin
        wbit();
        n++;
      end while (st.byte_valid !== 1'b1 && n < 16);
      w = {pat, pat} << ((8 - off[i] % 8) % 8);
      chk({24'h0, st.byte_data}, {24'h0, w[15:8]}, "byte boundary");
      chk({31'h0, st.bit_data}, {31'h0, w[8]}, "last bit of byte");
      rdr(32'h8);
      chk(rd, {24'h0, w[15:8]}, "data register byte");
    end
    wr(32'h4, 32'h2, 2'h0);
    rdr(32'h4);
    chk({31'h0, rd[1]}, 32'h0, "sticky flag not cleared");
  endtask

  // one sync then a whole frame counted in every line mode
  task automatic s_frames;
    int len [4] = '{193, 256, 512, 1024};
    int n;
    for (int m = 0; m < 4; m++) begin
      cfg(2'(m), 2'b10, 1'b0, 1'b0);
      n = 0;
      do begin
        wbit();
        n++;
      end while (!(st.frame_start === 1'b1 && rx_aligned === 1'b1) && n < 64);
      n = 0;
      do begin
        wbit();
        n++;
      end while (st.frame_start !== 1'b1 && n < 1100);
      chk(n, len[m], "frame length");
    end
  endtask

  // reset, then scenarios
  initial begin
    {aresetn, run, clk_inv, sync_inv, half, sync_req} = 6'h00;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    s_axi_wstrb = 4'hF;
    s_axi_awprot = 3'h0;
    s_axi_arprot = 3'h0;
    pat = 8'hB4;
    n_mismatch = 0;
    checks = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    run <= 1'b1;
    s_regs();
    s_sync();
    s_frames();
    summarize();
  end
endmodule
